// ---- shared/mcd_params.svh ----
/*
  Constants of the motion command decoder: frame layout, status codes,
  type-field limits and reset values.
  Assumes it is included by bare name wherever the constants are used.
*/
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define MCD_LAST_BYTE    4'h8
`define MCD_MOD_ADDR     8'h01
`define MCD_REPLY_ADDR   8'h02
`define MCD_USER_BANK    8'h02

// ----------------------------------------------------------------
// Reply status codes
// ----------------------------------------------------------------
`define MCD_ST_OK        8'h64
`define MCD_ST_CSUM      8'h01
`define MCD_ST_CMD       8'h02
`define MCD_ST_TYPE      8'h03
`define MCD_ST_VALUE     8'h04

// ----------------------------------------------------------------
// Type-field limits and reset values
// ----------------------------------------------------------------
`define MCD_MOVE_TYPE_MAX 8'h02
`define MCD_ACCU_IMMEDIATE_OP_TYPE_MAX 8'h09
`define MCD_XOP_TYPE_MAX  8'h0a
`define MCD_ACCU_RST      32'h0000_0000
`define MCD_XREG_RST      32'h0000_0000

`endif

// ---- shared/mcd_pkg.sv ----
/*
  Types of the motion command decoder: command codes, operations,
  decoder states and the structs that carry frames and replies.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package mcd_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    rotate_cw = 8'h01, rotate_ccw = 8'h02, motor_halt = 8'h03,
    move_to_target = 8'h04, axis_setting_write = 8'h05,
    axis_setting_read = 8'h06, module_setting_write = 8'h09,
    module_setting_read = 8'h0a, user_var_save = 8'h0b,
    user_var_reload = 8'h0c, home_search = 8'h0d,
    input_sample = 8'h0f, accu_immediate_op = 8'h13,
    accu_compare = 8'h14, branch_if = 8'h15, branch_always = 8'h16,
    sub_call = 8'h17, sub_return = 8'h18, irq_on = 8'h19,
    irq_off = 8'h1a, wait_event = 8'h1b, program_halt = 8'h1c,
    target_stored_write = 8'h1e, target_stored_read = 8'h1f, target_stored_capture = 8'h20,
    accu_xreg_op = 8'h21, accu_to_axis_setting = 8'h22,
    accu_to_module_setting = 8'h23, error_flag_clear = 8'h24,
    irq_handler_define = 8'h25, irq_return = 8'h26,
    accu_to_target_stored = 8'h27
  } mcd_cmd_t;

  // Arithmetic operations selected by the type field
  typedef enum logic [7:0] {
    OP_ADD = 8'h00, OP_SUB = 8'h01, OP_MUL = 8'h02, OP_DIV = 8'h03,
    OP_MOD = 8'h04, OP_AND = 8'h05, OP_OR = 8'h06, OP_XOR = 8'h07,
    OP_NOT = 8'h08, OP_LOAD = 8'h09, OP_SWAP = 8'h0a
  } mcd_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ACT = 2'b01, ST_REPLY = 2'b10, ST_WAIT_TX = 2'b11
  } mcd_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } mcd_frame_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } mcd_act_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  cmd;
    logic [31:0] value;
  } mcd_reply_t;

  typedef struct packed {
    logic zero;
    logic greater;
    logic less;
  } mcd_flags_t;

endpackage

`default_nettype wire

// ---- design/mcd_frame_rx.sv ----
/*
  Frame assembler: collects address, command, type, selector, four value
  bytes (MSB first) and checksum, and flags whether the sum matches.
  Assumes bytes arrive synchronous to core_clk_in, one per valid cycle.
*/
`include "mcd_params.svh"
`default_nettype none

module mcd_frame_rx (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        accept_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  output mcd_pkg::mcd_frame_t frame_out,
  output logic             frame_valid_out,
  output logic             csum_ok_out
);
  import mcd_pkg::*;

  logic [3:0]  count;
  logic [3:0]  next_count;
  logic [7:0]  sum;
  logic [7:0]  next_sum;
  logic [63:0] shreg;
  logic [63:0] next_shreg;
  logic        next_frame_valid;
  logic        next_csum_ok;

  // Bytes seen while not accepting are dropped and the count restarts
  always_comb begin
    next_count       = count;
    next_sum         = sum;
    next_shreg       = shreg;
    next_frame_valid = 1'b0;
    next_csum_ok     = csum_ok_out;
    if (!accept_in) begin
      next_count = 4'h0;
      next_sum   = 8'h00;
    end else if (byte_valid_in) begin
      if (count == `MCD_LAST_BYTE) begin
        next_frame_valid = 1'b1;
        next_csum_ok     = (sum == byte_in);
        next_count       = 4'h0;
        next_sum         = 8'h00;
      end else begin
        next_shreg = {shreg[55:0], byte_in};
        next_sum   = sum + byte_in;
        next_count = count + 4'h1;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count           <= 4'h0;
      sum             <= 8'h00;
      shreg           <= 64'h0;
      frame_valid_out <= 1'b0;
      csum_ok_out     <= 1'b0;
    end else if (ce_in) begin
      count           <= next_count;
      sum             <= next_sum;
      shreg           <= next_shreg;
      frame_valid_out <= next_frame_valid;
      csum_ok_out     <= next_csum_ok;
    end
  end

  assign frame_out = mcd_frame_t'(shreg);

endmodule // mcd_frame_rx

`default_nettype wire

// ---- design/mcd_reply_tx.sv ----
/*
  Reply serialiser: sends reply address, module address, status,
  command, four value bytes (MSB first) and the 8-bit sum of them all.
  Assumes start_in is raised only while no reply is in flight.
*/
`include "mcd_params.svh"
`default_nettype none

module mcd_reply_tx (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  mcd_pkg::mcd_reply_t reply_in,
  input  wire logic [7:0]  reply_addr_in,
  input  wire logic [7:0]  mod_addr_in,
  input  wire logic        tx_ready_in,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  output logic             done_out
);
  import mcd_pkg::*;

  logic [71:0] shreg;
  logic [71:0] next_shreg;
  logic [3:0]  count;
  logic [3:0]  next_count;
  logic        next_valid;
  logic        next_done;
  logic [7:0]  csum;

  // Checksum over the eight leading reply bytes
  assign csum = reply_addr_in + mod_addr_in + reply_in.status
              + reply_in.cmd + reply_in.value[31:24]
              + reply_in.value[23:16] + reply_in.value[15:8]
              + reply_in.value[7:0];

  // Load on start, shift one byte per accepted transfer
  always_comb begin
    next_shreg = shreg;
    next_count = count;
    next_valid = tx_valid_out;
    next_done  = 1'b0;
    if (start_in && !tx_valid_out) begin
      next_shreg = {reply_addr_in, mod_addr_in, reply_in, csum};
      next_count = `MCD_LAST_BYTE;
      next_valid = 1'b1;
    end else if (tx_valid_out && tx_ready_in) begin
      if (count == 4'h0) begin
        next_valid = 1'b0;
        next_done  = 1'b1;
      end else begin
        next_shreg = {shreg[63:0], 8'h00};
        next_count = count - 4'h1;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shreg        <= 72'h0;
      count        <= 4'h0;
      tx_valid_out <= 1'b0;
      done_out     <= 1'b0;
    end else if (ce_in) begin
      shreg        <= next_shreg;
      count        <= next_count;
      tx_valid_out <= next_valid;
      done_out     <= next_done;
    end
  end

  assign tx_data_out = shreg[71:64];

endmodule // mcd_reply_tx

`default_nettype wire

// ---- design/mcd_decoder.sv ----
/*
  Motion command decoder: takes framed binary commands from the host,
  checks them, runs accumulator work locally, hands every other action
  to the motion core over a request/done port, and sends one reply.
  Assumes the host waits for each reply before the next command, and
  that the motion core answers every request with one done pulse.
*/
`include "mcd_params.svh"
`default_nettype none

module mcd_decoder #(
  parameter logic [7:0] MOD_ADDR   = `MCD_MOD_ADDR,
  parameter logic [7:0] REPLY_ADDR = `MCD_REPLY_ADDR,
  parameter logic [7:0] USER_BANK  = `MCD_USER_BANK
) (
  input  wire logic         core_clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         ce_in,
  input  wire logic         rx_valid_in,
  input  wire logic [7:0]   rx_data_in,
  output logic              rx_ready_out,
  output logic              tx_valid_out,
  output logic [7:0]        tx_data_out,
  input  wire logic         tx_ready_in,
  output logic              act_valid_out,
  output mcd_pkg::mcd_act_t act_req_out,
  input  wire logic         act_done_in,
  input  wire logic [7:0]   act_status_in,
  input  wire logic [31:0]  act_value_in,
  output logic [31:0]       accu_out,
  output logic [31:0]       xreg_out,
  output mcd_pkg::mcd_flags_t flags_out
);
  import mcd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mcd_state_t state;
  mcd_state_t next_state;
  mcd_frame_t frame;
  logic       frame_valid;
  logic       csum_ok;
  logic       tx_done;
  mcd_reply_t reply;
  mcd_reply_t next_reply;
  mcd_act_t   next_act_req;
  logic       next_act_valid;
  logic [31:0] next_accu;
  logic [31:0] next_xreg;
  mcd_flags_t next_flags;
  logic [31:0] alu_res;
  logic        alu_bad;
  logic [31:0] operand;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Every defined code; anything else is rejected outright
  function automatic logic known_cmd(input logic [7:0] c);
    logic k;
    k = 1'b0;
    case (c)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0a,
      8'h0b, 8'h0c, 8'h0d, 8'h0f, 8'h13, 8'h14, 8'h15, 8'h16,
      8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1e, 8'h1f,
      8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
      8'h27: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  // Second operand: immediate for code 19, X register for code 33
  assign operand = (frame.cmd == accu_xreg_op) ? xreg_out : frame.value;

  // Shared arithmetic; division and remainder are signed and a zero
  // divisor is reported rather than silently producing garbage
  always_comb begin
    alu_res = accu_out;
    alu_bad = 1'b0;
    case (frame.typ)
      OP_ADD: alu_res = accu_out + operand;
      OP_SUB: alu_res = accu_out - operand;
      OP_MUL: alu_res = 32'(accu_out * operand);
      OP_DIV: begin
        if (operand == 32'h0) begin
          alu_bad = 1'b1;
        end else begin
          alu_res = 32'($signed(accu_out) / $signed(operand));
        end
      end
      OP_MOD: begin
        if (operand == 32'h0) begin
          alu_bad = 1'b1;
        end else begin
          alu_res = 32'($signed(accu_out) % $signed(operand));
        end
      end
      OP_AND: alu_res = accu_out & operand;
      OP_OR:  alu_res = accu_out | operand;
      OP_XOR: alu_res = accu_out ^ operand;
      OP_NOT: alu_res = ~accu_out;
      OP_LOAD: alu_res = operand;
      default: alu_res = accu_out;
    endcase
  end

  // ----------------------------------------------------------------
  // Link ends
  // ----------------------------------------------------------------
  // Bytes are only taken while idle so a reply is never overrun
  assign rx_ready_out = (state == ST_IDLE);

  mcd_frame_rx u_rx (
    .core_clk_in     (core_clk_in),
    .arst_n_in       (arst_n_in),
    .ce_in           (ce_in),
    .accept_in       (rx_ready_out),
    .byte_valid_in   (rx_valid_in),
    .byte_in         (rx_data_in),
    .frame_out       (frame),
    .frame_valid_out (frame_valid),
    .csum_ok_out     (csum_ok)
  );

  mcd_reply_tx u_tx (
    .core_clk_in   (core_clk_in),
    .arst_n_in     (arst_n_in),
    .ce_in         (ce_in),
    .start_in      (state == ST_REPLY),
    .reply_in      (reply),
    .reply_addr_in (REPLY_ADDR),
    .mod_addr_in   (MOD_ADDR),
    .tx_ready_in   (tx_ready_in),
    .tx_valid_out  (tx_valid_out),
    .tx_data_out   (tx_data_out),
    .done_out      (tx_done)
  );

  // ----------------------------------------------------------------
  // Decode and sequencing
  // ----------------------------------------------------------------
  // Checks run in a fixed order: address, checksum, code, type, value
  always_comb begin
    next_state     = state;
    next_reply     = reply;
    next_act_req   = act_req_out;
    next_act_valid = act_valid_out;
    next_accu      = accu_out;
    next_xreg      = xreg_out;
    next_flags     = flags_out;
    case (state)
      ST_IDLE: begin
        if (frame_valid && frame.addr == MOD_ADDR) begin
          next_state       = ST_REPLY;
          next_reply.cmd   = frame.cmd;
          next_reply.value = 32'h0;
          next_reply.status = `MCD_ST_OK;
          if (!csum_ok) begin
            next_reply.status = `MCD_ST_CSUM;
          end else if (!known_cmd(frame.cmd)) begin
            next_reply.status = `MCD_ST_CMD;
          end else begin
            case (frame.cmd)
              move_to_target: begin
                if (frame.typ > `MCD_MOVE_TYPE_MAX) begin
                  next_reply.status = `MCD_ST_TYPE;
                end else begin
                  next_state = ST_ACT;
                end
              end
              user_var_save, user_var_reload: begin
                if (frame.bank != USER_BANK) begin
                  next_reply.status = `MCD_ST_VALUE;
                end else begin
                  next_state = ST_ACT;
                end
              end
              accu_immediate_op: begin
                if (frame.typ > `MCD_ACCU_IMMEDIATE_OP_TYPE_MAX) begin
                  next_reply.status = `MCD_ST_TYPE;
                end else if (alu_bad) begin
                  next_reply.status = `MCD_ST_VALUE;
                end else begin
                  next_accu        = alu_res;
                  next_reply.value = alu_res;
                end
              end
              accu_xreg_op: begin
                if (frame.typ > `MCD_XOP_TYPE_MAX) begin
                  next_reply.status = `MCD_ST_TYPE;
                end else if (frame.typ == OP_LOAD) begin
                  next_xreg        = accu_out;
                  next_reply.value = accu_out;
                end else if (frame.typ == OP_SWAP) begin
                  next_xreg        = accu_out;
                  next_accu        = xreg_out;
                  next_reply.value = xreg_out;
                end else if (alu_bad) begin
                  next_reply.status = `MCD_ST_VALUE;
                end else begin
                  next_accu        = alu_res;
                  next_reply.value = alu_res;
                end
              end
              accu_compare: begin
                next_flags.zero    = (accu_out == frame.value);
                next_flags.greater = $signed(accu_out)
                                   > $signed(frame.value);
                next_flags.less    = $signed(accu_out)
                                   < $signed(frame.value);
              end
              default: begin
                next_state = ST_ACT;
              end
            endcase
            next_act_req.cmd   = frame.cmd;
            next_act_req.typ   = frame.typ;
            next_act_req.bank  = frame.bank;
            next_act_req.value = frame.value;
            if (frame.cmd == accu_to_axis_setting ||
                frame.cmd == accu_to_module_setting ||
                frame.cmd == accu_to_target_stored) begin
              next_act_req.value = accu_out;
            end
            next_act_valid = (next_state == ST_ACT);
          end
        end
      end
      ST_ACT: begin
        // Read results go only into the reply, never the accumulator
        if (act_done_in) begin
          next_act_valid    = 1'b0;
          next_reply.status = act_status_in;
          next_reply.value  = act_value_in;
          next_state        = ST_REPLY;
        end
      end
      ST_REPLY: begin
        next_state = ST_WAIT_TX;
      end
      ST_WAIT_TX: begin
        if (tx_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Whole block freezes while the clock enable is low
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state         <= ST_IDLE;
      reply         <= '0;
      act_req_out   <= '0;
      act_valid_out <= 1'b0;
      accu_out      <= `MCD_ACCU_RST;
      xreg_out      <= `MCD_XREG_RST;
      flags_out     <= '0;
    end else if (ce_in) begin
      state         <= next_state;
      reply         <= next_reply;
      act_req_out   <= next_act_req;
      act_valid_out <= next_act_valid;
      accu_out      <= next_accu;
      xreg_out      <= next_xreg;
      flags_out     <= next_flags;
    end
  end

endmodule // mcd_decoder

`default_nettype wire

// ---- bench/mcd_decoder_sva.sv ----
/*
  Checker of the decoder's host, reply and action ports.
  Assumes ce_in stays high, as the bench keeps it; bound below.
*/
`default_nettype none

module mcd_decoder_sva (
  input wire logic              core_clk_in,
  input wire logic              arst_n_in,
  input wire logic              rx_ready_out,
  input wire logic              tx_valid_out,
  input wire logic [7:0]        tx_data_out,
  input wire logic              tx_ready_in,
  input wire logic              act_valid_out,
  input wire mcd_pkg::mcd_act_t act_req_out,
  input wire logic              act_done_in,
  input wire logic [31:0]       accu_out
);
  import mcd_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Host may not send while a reply is going out
  property p_busy; tx_valid_out |-> !rx_ready_out; endproperty
  a_busy: assert property (p_busy) else $error("ready during reply");
  property p_hold;
    act_valid_out && !act_done_in |=> act_valid_out && $stable(act_req_out);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_drop; act_valid_out && act_done_in |=> !act_valid_out; endproperty
  a_drop: assert property (p_drop) else $error("request kept");
  property p_txh;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  a_txh: assert property (p_txh) else $error("reply byte moved");
  property p_after; $fell(act_valid_out) |-> ##[1:3] $rose(tx_valid_out);
  endproperty
  a_after: assert property (p_after) else $error("late reply");
  property p_unk;
    act_valid_out |-> !(act_req_out.cmd inside {8'h07, 8'h08, 8'h0e,
      8'h10, 8'h11, 8'h12, 8'h1d, 8'h13, 8'h14, 8'h21});
  endproperty
  a_unk: assert property (p_unk) else $error("bad code passed on");
  property p_accu; act_valid_out |=> $stable(accu_out); endproperty
  a_accu: assert property (p_accu) else $error("accu changed");
  property p_first; $rose(tx_valid_out) |-> tx_data_out == 8'h02;
  endproperty
  a_first: assert property (p_first) else $error("bad reply address");
endmodule // mcd_decoder_sva

bind mcd_decoder mcd_decoder_sva u_sva (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .rx_ready_out(rx_ready_out),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
  .tx_ready_in(tx_ready_in), .act_valid_out(act_valid_out),
  .act_req_out(act_req_out), .act_done_in(act_done_in),
  .accu_out(accu_out));

`default_nettype wire

// ---- bench/mcd_core_model.sv ----
/*
  Motion core stand-in: one done pulse per request, fast or slow.
  Assumes the request holds until done and drops right after.
*/
`default_nettype none

module mcd_core_model (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_in,
  input  wire logic [31:0] value_in,
  input  wire logic        slow_in,
  output logic             done_out,
  output logic [7:0]       status_out,
  output logic [31:0]      value_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic       seen;
  // Outside done the answer lines wander, so stale data is not trusted
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 5'h00;
      seen <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      cnt <= cnt + 5'h01;
      status_out <= {3'h0, cnt};
      value_out <= {27'h0, cnt} ^ value_in;
      if (!req_in) seen <= 1'b0;
      if (req_in && !seen && cnt >= (slow_in ? 5'h14 : 5'h01)) begin
        done <= 1'b1;
        seen <= 1'b1;
        cnt <= 5'h00;
        status_out <= 8'h64;
        value_out <= ~value_in;
      end
    end
  end
  assign done_out = done;
  logic done;
endmodule // mcd_core_model

`default_nettype wire

// ---- bench/motion_command_decoder_tb_top.sv ----
/*
  Self-checking bench of the decoder: frames in, replies checked.
  Assumes the package and the core model are compiled first.
*/
`default_nettype none

module motion_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mcd_pkg::*;
  logic clk = 0, arst_n = 0, rx_valid = 0, tx_ready = 0, slow = 0;
  logic rx_ready, tx_valid, act_valid, done;
  logic [7:0] rx_data = 8'h00, tx_data, status;
  logic [31:0] cval, accu, xreg, s = 32'hc28be179, ea = 0, ex = 0;
  mcd_act_t req;
  mcd_flags_t flags;
  mcd_reply_t q[$];
  mcd_reply_t r;
  logic [7:0] rb[9];
  logic [7:0] sum;
  int bi = 0, got = 0, cyc = 0, mismatches = 0, tests_run = 0;
  always #2 clk = ~clk;
  mcd_decoder u_dut (.core_clk_in(clk), .arst_n_in(arst_n), .ce_in(1'b1),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .act_valid_out(act_valid), .act_req_out(req), .act_done_in(done),
    .act_status_in(status), .act_value_in(cval), .accu_out(accu),
    .xreg_out(xreg), .flags_out(flags));
  mcd_core_model u_core (.clk_in(clk), .arst_n_in(arst_n),
    .req_in(act_valid), .value_in(req.value), .slow_in(slow),
    .done_out(done), .status_out(status), .value_out(cval));
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic push(input logic [7:0] st, c, input logic [31:0] v);
    q.push_back('{st, c, v});
  endtask
  // Whole frame, then wait for the reply; a foreign address gets none
  task automatic send(input logic [7:0] a, c, t, b, input logic [31:0] v,
                      input logic [7:0] e);
    logic [7:0] f[9];
    int n;
    f = '{a, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0], e};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    n = got;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #1 rx_valid = 1'b1;
      rx_data = f[i];
    end
    @(posedge clk);
    #1 rx_valid = 1'b0;
    if (a == 8'h01) begin
      while (got == n) @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
    end else begin
      repeat (40) @(posedge clk);
      chk("reply count", n, got);
    end
    chk("accu", ea, accu);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reply collector: the stalling sink takes one byte per handshake
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      rb[bi] = tx_data;
      bi++;
      if (bi == 9) begin
        bi = 0;
        got++;
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum += rb[i];
        if (q.size() == 0) chk("unexpected reply", 0, 1);
        else begin
          r = q.pop_front();
          chk("addr", 16'h0201, {rb[0], rb[1]});
          chk("status", r.status, rb[2]);
          chk("cmd", r.cmd, rb[3]);
          chk("value", r.value, {rb[4], rb[5], rb[6], rb[7]});
          chk("sum", sum, rb[8]);
        end
      end
    end
  end
  always @(posedge clk) begin
    #1 tx_ready = (rnd() % 4) != 0;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [7:0] lt[5] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h09};
    logic [7:0] ac[26] = '{1, 2, 3, 4, 5, 6, 9, 10, 11, 12, 13, 15, 21, 22,
      23, 24, 25, 26, 27, 28, 30, 31, 32, 34, 35, 36};
    logic [7:0] uk[9] = '{0, 7, 8, 14, 16, 17, 18, 29, 40};
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    foreach (lt[i]) begin
      v = rnd();
      case (lt[i])
        8'h00: ea = ea + v;
        8'h01: ea = ea - v;
        8'h05: ea = ea & v;
        8'h07: ea = ea ^ v;
        default: ea = v;
      endcase
      push(8'h64, 8'h13, ea);
      send(8'h01, 8'h13, lt[i], 8'h00, v, 8'h00);
    end
    ex = ea;
    push(8'h64, 8'h21, ea);
    send(8'h01, 8'h21, 8'h09, 8'h00, rnd(), 8'h00);
    ea = ea + ex;
    push(8'h64, 8'h21, ea);
    send(8'h01, 8'h21, 8'h00, 8'h00, 32'h0, 8'h00);
    chk("xreg", ex, xreg);
    for (int i = 0; i < 3; i++) begin
      v = ea + i - 1;
      push(8'h64, 8'h14, 32'h0);
      send(8'h01, 8'h14, 8'h00, 8'h00, v, 8'h00);
      chk("flags", {ea == v, $signed(ea) > $signed(v),
        $signed(ea) < $signed(v)}, flags);
    end
    for (int i = 0; i < 27; i++) begin
      v = rnd();
      slow = v[0];
      if (i == 26) ac[0] = 8'h27;
      push(8'h64, ac[i % 26], (ac[i % 26] inside {34, 35, 39}) ? ~ea : ~v);
      send(8'h01, ac[i % 26], 8'(i % 3), 8'h02, v, 8'h00);
    end
    foreach (uk[i]) begin
      push(8'h02, uk[i], 32'h0);
      send(8'h01, uk[i], 8'h00, 8'h02, rnd(), 8'h00);
    end
    push(8'h03, 8'h04, 32'h0);
    send(8'h01, 8'h04, 8'h03, 8'h00, rnd(), 8'h00);
    push(8'h04, 8'h0b, 32'h0);
    send(8'h01, 8'h0b, 8'h00, 8'h01, rnd(), 8'h00);
    push(8'h04, 8'h13, 32'h0);
    send(8'h01, 8'h13, 8'h03, 8'h00, 32'h0, 8'h00);
    push(8'h01, 8'h05, 32'h0);
    send(8'h01, 8'h05, 8'h00, 8'h00, rnd(), 8'h01);
    send(8'h03, 8'h01, 8'h00, 8'h00, rnd(), 8'h00);
    chk("pending", 0, q.size());
    print_verdict();
  end
endmodule // motion_command_decoder_tb_top

`default_nettype wire
